// ### tb_top.sv
// Self-checking bench for the wake block: registers, group routing, key match.
// Assumes wk_kbd_model drives the keyboard lines and wk_checker is bound in.
`timescale 1ns/1ps

module tb_top;
  import wk_pkg::*;

  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  wk_reg_req_type reg_req = '0;
  logic [7:0]     reg_rdata;
  logic           ext_clk32 = 1'b0;
  logic           kbd_clk;
  logic           kbd_data;
  logic           group_smi_in = 1'b0;
  logic           wake_event_o;
  logic           wake_event_oe_n;
  logic           key_match_seen;
  int             n_errors = 0;
  int             total_checks = 0;
  int             n_seen = 0;

  always #25 core_clk = ~core_clk;
  // External 32.768 kHz source, free running and unrelated to core_clk
  always #15259 ext_clk32 <= ~ext_clk32;
  always @(posedge core_clk)
    if (key_match_seen === 1'b1)
      n_seen <= n_seen + 1;

  wk_wake_top i_dut
  (
    .core_clk        (core_clk),
    .rst             (rst),
    .reg_req         (reg_req),
    .reg_rdata       (reg_rdata),
    .ext_clk32       (ext_clk32),
    .kbd_clk_in      (kbd_clk),
    .kbd_data_in     (kbd_data),
    .group_smi_in    (group_smi_in),
    .wake_event_o    (wake_event_o),
    .wake_event_oe_n (wake_event_oe_n),
    .key_match_seen  (key_match_seen)
  );
  wk_kbd_model i_kbd
  (
    .kbd_clk  (kbd_clk),
    .kbd_data (kbd_data)
  );

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    @(negedge core_clk);
    check8(reg_rdata, exp, what);
  endtask
  // Mask 01 looks at the enable alone: an open-drain pin at rest is not driven
  task automatic pin_chk(input logic [1:0] exp, input logic [1:0] mask);
    repeat (4) @(negedge core_clk);
    check8({6'h00, {wake_event_o, wake_event_oe_n} & mask}, {6'h00, exp & mask}, "pin");
  endtask
  // Returns 100 us after the last clock fall of the frame
  task automatic frame(input logic [7:0] c, input logic bad, input int n);
    // Start on a rising edge so every line change lands by NBA, never racing the sampler
    @(posedge core_clk);
    i_kbd.send_frame(c, bad, n);
    #68000;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    rd_chk(OFS_SCAN, 8'h00, "scan reset");
    rd_chk(OFS_CLK_CTL, 8'h00, "clk ctl reset");
    rd_chk(OFS_PIN_CTL, 8'h84, "pin ctl reset");
    rd_chk(OFS_STS1, 8'h00, "sts1 reset");
    wr(8'h77, 8'hFF);
    rd_chk(8'h77, 8'h00, "unmapped");
    wr(OFS_SCAN, 8'hA5);
    rd_chk(OFS_SCAN, 8'hA5, "scan");
    wr(OFS_CLK_CTL, 8'hFF);
    rd_chk(OFS_CLK_CTL, 8'h03, "clk ctl");
    wr(OFS_CLK_CTL, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_group;
    @(posedge core_clk);
    group_smi_in <= 1'b1;
    rd_chk(OFS_STS3, 8'h00, "sts3 unrouted");
    wr(OFS_SMI_ENABLE_TWO, 8'h20);
    rd_chk(OFS_STS3, 8'h08, "sts3 routed");
    @(posedge core_clk);
    group_smi_in <= 1'b0;
    wr(OFS_EN3, 8'h08);
    pin_chk(2'b01, 2'b01);
    rd_chk(OFS_WAKE_CTL, 8'h80, "summary");
    wr(OFS_WAKE_CTL, 8'h01);
    pin_chk(2'b00, 2'b11);
    wr(OFS_EN3, 8'h00);
    pin_chk(2'b01, 2'b01);
    wr(OFS_STS3, 8'h00);
    rd_chk(OFS_STS3, 8'h08, "sts3 write 0");
    wr(OFS_STS3, 8'h08);
    rd_chk(OFS_STS3, 8'h00, "sts3 write 1");
    wr(OFS_EN3, 8'h08);
    wr(OFS_PIN_CTL, 8'h06);
    pin_chk(2'b00, 2'b11);
    @(posedge core_clk);
    group_smi_in <= 1'b1;
    pin_chk(2'b10, 2'b11);
    @(posedge core_clk);
    group_smi_in <= 1'b0;
    wr(OFS_STS3, 8'h08);
    pin_chk(2'b00, 2'b11);
    wr(OFS_WAKE_CTL, 8'h81);
    rd_chk(OFS_WAKE_CTL, 8'h01, "summary clear");
    wr(OFS_EN3, 8'h00);
    wr(OFS_SMI_ENABLE_TWO, 8'h00);
    $display("test group done");
  endtask
  // A cut frame first: only an aborted matcher finds the full frame after it
  task automatic t_key;
    frame(8'hA5, 1'b0, 4);
    frame(8'hA5, 1'b0, 11);
    rd_chk(OFS_STS1, 8'h20, "key status");
    check8(8'(n_seen), 8'h01, "key pulses");
    pin_chk(2'b00, 2'b11);
    wr(OFS_EN1, 8'h20);
    pin_chk(2'b10, 2'b11);
    rd_chk(OFS_WAKE_CTL, 8'h81, "summary key");
    wr(OFS_STS1, 8'h20);
    wr(OFS_WAKE_CTL, 8'h81);
    rd_chk(OFS_WAKE_CTL, 8'h01, "summary key clear");
    $display("test key done");
  endtask
  task automatic t_parity;
    frame(8'hA5, 1'b1, 11);
    rd_chk(OFS_STS1, 8'h00, "bad parity");
    check8(8'(n_seen), 8'h01, "bad parity pulses");
    frame(8'h5A, 1'b0, 11);
    rd_chk(OFS_STS1, 8'h00, "wrong code");
    check8(8'(n_seen), 8'h01, "wrong code pulses");
    $display("test parity done");
  endtask
  task automatic t_off;
    wr(OFS_CLK_CTL, 8'h02);
    frame(8'hA5, 1'b0, 11);
    rd_chk(OFS_STS1, 8'h00, "matcher off");
    check8(8'(n_seen), 8'h01, "matcher off pulses");
    $display("test off done");
  endtask
  task automatic t_ext;
    wr(OFS_CLK_CTL, 8'h01);
    frame(8'hA5, 1'b0, 11);
    rd_chk(OFS_STS1, 8'h20, "external clock");
    check8(8'(n_seen), 8'h02, "external pulses");
    $display("test ext done");
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_group();
    t_key();
    t_parity();
    t_off();
    t_ext();
    report_and_stop();
  end
  initial
  begin
    repeat (102000) @(posedge core_clk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule

// ### wk_checker.sv
// Checker for the wake block: register map, pin gating and key-match timing.
// Sees only the wk_wake_top ports; bound at the foot of this file.
`timescale 1ns/1ps

module wk_checker
  import wk_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire wk_pkg::wk_reg_req_type reg_req,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   kbd_clk_in,
  input wire logic                   group_smi_in,
  input wire logic                   wake_event_o,
  input wire logic                   wake_event_oe_n,
  input wire logic                   key_match_seen
);
  logic [7:0]  scan_q;
  logic [1:0]  ctl_q;
  logic        gen_q;
  logic        route_q;
  logic        grp_en_q;
  logic        func_q;
  logic        pol_q;
  logic        kclk_q;
  logic [11:0] since_fall;
  logic        active;
  logic        mapped;

  assign active = !wake_event_oe_n && (wake_event_o == pol_q);
  assign mapped = reg_req.addr inside {OFS_WAKE_CTL, OFS_STS1, OFS_STS3, OFS_EN1, OFS_EN3,
                                       OFS_SMI_ENABLE_TWO, OFS_PIN_CTL, OFS_SCAN, OFS_CLK_CTL};

  // ----------------------------------------------------------
  // Shadow of the control registers
  // ----------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scan_q   <= RST_SCAN;
      ctl_q    <= RST_CLK_CTL[1:0];
      gen_q    <= 1'b0;
      route_q  <= 1'b0;
      grp_en_q <= 1'b0;
      func_q   <= RST_PIN_CTL[FUNC_BIT];
      pol_q    <= RST_PIN_CTL[POL_BIT];
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_SCAN:     scan_q   <= reg_req.wdata;
        OFS_CLK_CTL:  ctl_q    <= reg_req.wdata[1:0];
        OFS_WAKE_CTL: gen_q    <= reg_req.wdata[GEN_BIT];
        OFS_SMI_ENABLE_TWO:  route_q  <= reg_req.wdata[ROUTE_BIT];
        OFS_EN3:      grp_en_q <= reg_req.wdata[GRP_BIT];
        OFS_PIN_CTL:
        begin
          func_q <= reg_req.wdata[FUNC_BIT];
          pol_q  <= reg_req.wdata[POL_BIT];
        end
        default: ;
      endcase
    end
  end

  // Saturating so a long idle line cannot wrap into a false match window
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      kclk_q     <= 1'b1;
      since_fall <= 12'hFFF;
    end
    else
    begin
      kclk_q <= kbd_clk_in;
      if (kclk_q && !kbd_clk_in)
        since_fall <= 12'h000;
      else if (since_fall != 12'hFFF)
        since_fall <= since_fall + 12'h001;
    end
  end

  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  pulse_one_a: assert property (key_match_seen |=> !key_match_seen)
    else $error("key match pulse longer than one cycle");
  key_late_a: assert property (key_match_seen |-> since_fall < 12'h7D1)
    else $error("key match not within 100 us of last clock fall");
  key_off_a: assert property (ctl_q[1] && $past(ctl_q[1], 3) |-> !key_match_seen)
    else $error("key match while matcher switched off");
  global_off_a: assert property (!gen_q && !$past(gen_q) |-> !active)
    else $error("wake pin active with global enable off");
  grp_pin_a: assert property (group_smi_in && route_q && grp_en_q && gen_q && func_q
    |-> ##[1:3] active)
    else $error("group event did not reach wake pin");
  scan_read_a: assert property (reg_req.rd && reg_req.addr == OFS_SCAN
    |=> reg_rdata == scan_q)
    else $error("scan code readback wrong");
  ctl_read_a: assert property (reg_req.rd && reg_req.addr == OFS_CLK_CTL
    |=> reg_rdata == {6'h00, ctl_q})
    else $error("clock source control readback wrong");
  unmapped_rd_a: assert property (reg_req.rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule

bind wk_wake_top wk_checker i_chk
(
  .core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .kbd_clk_in(kbd_clk_in), .group_smi_in(group_smi_in), .wake_event_o(wake_event_o),
  .wake_event_oe_n(wake_event_oe_n), .key_match_seen(key_match_seen)
);

// ### wk_kbd_model.sv
// Keyboard sending scan-code frames on its clock and data lines.
// Lines have pull-ups, so both rest high between frames.
`timescale 1ns/1ps

module wk_kbd_model
(
  output logic kbd_clk,
  output logic kbd_data
);
  localparam time HALF_NS = 32000;
  localparam time IDLE_NS = 100000;

  initial
  begin
    kbd_clk  = 1'b1;
    kbd_data = 1'b1;
  end

  // Short n_fall leaves the frame unfinished with the clock parked high
  task automatic send_frame(input logic [7:0] code, input logic bad_par, input int n_fall);
    logic [10:0] bits;
    bits = {1'b1, ~^code ^ bad_par, code, 1'b0};
    #(IDLE_NS);
    for (int i = 0; i < n_fall; i++)
    begin
      kbd_data <= bits[i];
      #(HALF_NS);
      kbd_clk <= 1'b0;
      #(HALF_NS);
      kbd_clk <= 1'b1;
    end
    kbd_data <= 1'b1;
  endtask
endmodule

// ### wk_pkg.sv
// Constants, register map and carrier types for the wake-event block.
// Assumes a 20 MHz core clock and a one-port register access path.
package wk_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CORE_HZ      = 20_000_000;
  localparam int unsigned KCLK_HZ      = 32_768;
  localparam int unsigned DIV_CYCLES   = CORE_HZ / KCLK_HZ;
  localparam int unsigned LOSS_CYCLES  = 4 * DIV_CYCLES;
  localparam int unsigned IDLE_MIN_US  = 115;
  localparam int unsigned IDLE_MAX_US  = 145;
  localparam int unsigned IDLE_MIN_RAW = (IDLE_MIN_US * KCLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned IDLE_MAX_RAW = (IDLE_MAX_US * KCLK_HZ) / 1_000_000;
  localparam int unsigned IDLE_MIN_TICKS = (IDLE_MIN_RAW < 1) ? 1 : IDLE_MIN_RAW;
  localparam int unsigned IDLE_MAX_TICKS = (IDLE_MAX_RAW < 1) ? 1 : IDLE_MAX_RAW;

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam logic [3:0] CLK_START  = 4'h1;
  localparam logic [3:0] CLK_D7     = 4'h9;
  localparam logic [3:0] CLK_PARITY = 4'hA;
  localparam logic [3:0] CLK_STOP   = 4'hB;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE_CTL = 8'h00;
  localparam logic [7:0] OFS_STS1     = 8'h01;
  localparam logic [7:0] OFS_STS3     = 8'h03;
  localparam logic [7:0] OFS_EN1      = 8'h05;
  localparam logic [7:0] OFS_EN3      = 8'h07;
  localparam logic [7:0] OFS_SMI_ENABLE_TWO  = 8'h10;
  localparam logic [7:0] OFS_PIN_CTL  = 8'h20;
  localparam logic [7:0] OFS_SCAN     = 8'h5F;
  localparam logic [7:0] OFS_CLK_CTL  = 8'hF0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned KEY_BIT     = 5;
  localparam int unsigned GRP_BIT     = 3;
  localparam int unsigned ROUTE_BIT   = 5;
  localparam int unsigned EXT32_BIT   = 0;
  localparam int unsigned KDIS_BIT    = 1;
  localparam int unsigned GEN_BIT     = 0;
  localparam int unsigned SUMMARY_BIT = 7;
  localparam int unsigned POL_BIT     = 1;
  localparam int unsigned FUNC_BIT    = 2;
  localparam int unsigned ODRAIN_BIT  = 7;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_SCAN    = 8'h00;
  localparam logic [7:0] RST_CLK_CTL = 8'h00;
  localparam logic [7:0] RST_PIN_CTL = 8'h84;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wk_reg_req_type;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_FRAME
  } wk_match_state_type;

endpackage

// ### wk_tick_gen.sv
// 32 kHz tick source for the key matcher: external pin or divided core clock.
// The external pin is a free-running 32 kHz level sampled on core_clk.
`timescale 1ns/1ps

module wk_tick_gen
  import wk_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ext_sel,
  input  wire logic gate_off,
  input  wire logic ext_clk32,
  output logic      tick,
  output logic      clk_ok
);

  logic        e1;
  logic        e2;
  logic        e3;
  logic [9:0]  div_cnt;
  logic [11:0] loss_cnt;
  logic        next_e1;
  logic        next_e2;
  logic        next_e3;
  logic [9:0]  next_div_cnt;
  logic [11:0] next_loss_cnt;
  logic        next_tick;
  logic        next_clk_ok;
  logic        ext_edge;
  logic        div_wrap;

  always_comb
  begin
    next_e1       = ext_clk32;
    next_e2       = e1;
    next_e3       = e2;
    ext_edge      = e2 & ~e3;
    div_wrap      = (div_cnt == 10'(DIV_CYCLES - 1));
    next_div_cnt  = div_wrap ? 10'h000 : div_cnt + 10'h001;
    // Loss watch keeps the matcher idle if the external crystal is absent
    if (!ext_sel || ext_edge)
    begin
      next_loss_cnt = 12'h000;
    end
    else if (loss_cnt != 12'(LOSS_CYCLES))
    begin
      next_loss_cnt = loss_cnt + 12'h001;
    end
    else
    begin
      next_loss_cnt = loss_cnt;
    end
    next_clk_ok = !ext_sel || (loss_cnt != 12'(LOSS_CYCLES));
    // Gating stops every tick so the matcher holds still when off
    next_tick   = ~gate_off & (ext_sel ? ext_edge : div_wrap);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      e1       <= 1'b0;
      e2       <= 1'b0;
      e3       <= 1'b0;
      div_cnt  <= 10'h000;
      loss_cnt <= 12'h000;
      tick     <= 1'b0;
      clk_ok   <= 1'b1;
    end
    else
    begin
      e1       <= next_e1;
      e2       <= next_e2;
      e3       <= next_e3;
      div_cnt  <= next_div_cnt;
      loss_cnt <= next_loss_cnt;
      tick     <= next_tick;
      clk_ok   <= next_clk_ok;
    end
  end

endmodule

// ### wk_wake_top.sv
// Wake-event logic: group SMI routing and keyboard scan-code matcher.
// Registers sit behind a simple one-cycle write/read port; all are standby powered.
`timescale 1ns/1ps

module wk_wake_top
  import wk_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire wk_pkg::wk_reg_req_type reg_req,
  output logic [7:0]                  reg_rdata,
  input  wire logic                   ext_clk32,
  input  wire logic                   kbd_clk_in,
  input  wire logic                   kbd_data_in,
  input  wire logic                   group_smi_in,
  output logic                        wake_event_o,
  output logic                        wake_event_oe_n,
  output logic                        key_match_seen
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] scan_code;
  logic [7:0] clk_ctl;
  logic [7:0] pin_ctl;
  logic       global_en;
  logic       summary;
  logic       key_sts;
  logic       key_en;
  logic       grp_sts;
  logic       grp_en;
  logic       smi_route;
  logic [7:0] next_scan_code;
  logic [7:0] next_clk_ctl;
  logic [7:0] next_pin_ctl;
  logic       next_global_en;
  logic       next_summary;
  logic       next_key_sts;
  logic       next_key_en;
  logic       next_grp_sts;
  logic       next_grp_en;
  logic       next_smi_route;
  logic [7:0] next_reg_rdata;

  // ------------------------------------------------------------
  // Matcher state
  // ------------------------------------------------------------
  wk_match_state_type state;
  wk_match_state_type next_state;
  logic       ks1;
  logic       ks2;
  logic       kprev;
  logic       ds1;
  logic       ds2;
  logic [3:0] high_cnt;
  logic [3:0] bit_num;
  logic [7:0] shift;
  logic       code_hit;
  logic       par_ok;
  logic       key_set;
  logic       next_ks1;
  logic       next_ks2;
  logic       next_kprev;
  logic       next_ds1;
  logic       next_ds2;
  logic [3:0] next_high_cnt;
  logic [3:0] next_bit_num;
  logic [7:0] next_shift;
  logic       next_code_hit;
  logic       next_par_ok;
  logic       next_key_set;

  // ------------------------------------------------------------
  // Misc
  // ------------------------------------------------------------
  logic tick;
  logic clk_ok;
  logic run;
  logic fall;
  logic pending;
  logic pin_active;
  logic pin_level;
  logic next_wake_event_o;
  logic next_wake_event_oe_n;
  logic next_key_match_seen;
  logic wr_sts1;
  logic wr_sts3;
  logic wr_ctl;

  // ------------------------------------------------------------
  // 32 kHz tick
  // ------------------------------------------------------------
  wk_tick_gen u_tick
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .ext_sel   (clk_ctl[EXT32_BIT]),
    .gate_off  (clk_ctl[KDIS_BIT]),
    .ext_clk32 (ext_clk32),
    .tick      (tick),
    .clk_ok    (clk_ok)
  );

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always_comb
  begin
    wr_sts1        = reg_req.wr && (reg_req.addr == OFS_STS1);
    wr_sts3        = reg_req.wr && (reg_req.addr == OFS_STS3);
    wr_ctl         = reg_req.wr && (reg_req.addr == OFS_WAKE_CTL);
    next_scan_code = scan_code;
    next_clk_ctl   = clk_ctl;
    next_pin_ctl   = pin_ctl;
    next_global_en = global_en;
    next_key_en    = key_en;
    next_grp_en    = grp_en;
    next_smi_route = smi_route;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_SCAN:     next_scan_code = reg_req.wdata;
        OFS_CLK_CTL:  next_clk_ctl   = reg_req.wdata & 8'h03;
        OFS_PIN_CTL:  next_pin_ctl   = reg_req.wdata & 8'h86;
        OFS_WAKE_CTL: next_global_en = reg_req.wdata[GEN_BIT];
        OFS_EN1:      next_key_en    = reg_req.wdata[KEY_BIT];
        OFS_EN3:      next_grp_en    = reg_req.wdata[GRP_BIT];
        OFS_SMI_ENABLE_TWO:  next_smi_route = reg_req.wdata[ROUTE_BIT];
        default:      next_scan_code = scan_code;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    next_grp_sts = (group_smi_in & smi_route)
                 | (grp_sts & ~(wr_sts3 & reg_req.wdata[GRP_BIT]));
    next_key_sts = key_set
                 | (key_sts & ~(wr_sts1 & reg_req.wdata[KEY_BIT]));
    // Summary cannot clear while a source stays pending
    next_summary = pending
                 | (summary & ~(wr_ctl & reg_req.wdata[SUMMARY_BIT]));
    next_reg_rdata = reg_rdata;
    if (reg_req.rd)
    begin
      next_reg_rdata = 8'h00;
      case (reg_req.addr)
        OFS_SCAN:     next_reg_rdata = scan_code;
        OFS_CLK_CTL:  next_reg_rdata = clk_ctl;
        OFS_PIN_CTL:  next_reg_rdata = pin_ctl;
        OFS_WAKE_CTL:
        begin
          next_reg_rdata[GEN_BIT]     = global_en;
          next_reg_rdata[SUMMARY_BIT] = summary;
        end
        OFS_STS1:     next_reg_rdata[KEY_BIT]   = key_sts;
        OFS_STS3:     next_reg_rdata[GRP_BIT]   = grp_sts;
        OFS_EN1:      next_reg_rdata[KEY_BIT]   = key_en;
        OFS_EN3:      next_reg_rdata[GRP_BIT]   = grp_en;
        OFS_SMI_ENABLE_TWO:  next_reg_rdata[ROUTE_BIT] = smi_route;
        default:      next_reg_rdata = 8'h00;
      endcase
    end
  end

  // Only the standby reset reaches these registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scan_code <= RST_SCAN;
      clk_ctl   <= RST_CLK_CTL;
      pin_ctl   <= RST_PIN_CTL;
      global_en <= 1'b0;
      summary   <= 1'b0;
      key_sts   <= 1'b0;
      key_en    <= 1'b0;
      grp_sts   <= 1'b0;
      grp_en    <= 1'b0;
      smi_route <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      scan_code <= next_scan_code;
      clk_ctl   <= next_clk_ctl;
      pin_ctl   <= next_pin_ctl;
      global_en <= next_global_en;
      summary   <= next_summary;
      key_sts   <= next_key_sts;
      key_en    <= next_key_en;
      grp_sts   <= next_grp_sts;
      grp_en    <= next_grp_en;
      smi_route <= next_smi_route;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ------------------------------------------------------------
  // Key matcher
  // ------------------------------------------------------------
  always_comb
  begin
    run           = ~clk_ctl[KDIS_BIT] & clk_ok;
    fall          = tick & kprev & ~ks2;
    next_ks1      = ks1;
    next_ks2      = ks2;
    next_kprev    = kprev;
    next_ds1      = ds1;
    next_ds2      = ds2;
    next_high_cnt = high_cnt;
    next_state    = state;
    next_bit_num  = bit_num;
    next_shift    = shift;
    next_code_hit = code_hit;
    next_par_ok   = par_ok;
    next_key_set  = 1'b0;
    if (tick)
    begin
      next_ks1   = kbd_clk_in;
      next_ks2   = ks1;
      next_ds1   = kbd_data_in;
      next_ds2   = ds1;
      next_kprev = ks2;
      // High time counted in ticks, saturating
      if (!ks2)
      begin
        next_high_cnt = 4'h0;
      end
      else if (high_cnt != 4'hF)
      begin
        next_high_cnt = high_cnt + 4'h1;
      end
    end
    case (state)
      MS_IDLE:
      begin
        next_bit_num = 4'h0;
        // Start bit must read 0 after a full idle-high interval
        if (fall && (high_cnt >= 4'(IDLE_MIN_TICKS)) && !ds2)
        begin
          next_state   = MS_FRAME;
          next_bit_num = CLK_START;
        end
      end
      MS_FRAME:
      begin
        if (tick && ks2 && (high_cnt >= 4'(IDLE_MAX_TICKS)))
        begin
          next_state = MS_IDLE;
        end
        else if (fall)
        begin
          next_bit_num = bit_num + 4'h1;
          if (bit_num < CLK_D7)
          begin
            next_shift = {ds2, shift[7:1]};
          end
          else if (bit_num == CLK_D7)
          begin
            next_code_hit = (shift == scan_code);
            next_par_ok   = ^{shift, ds2};
          end
          else
          begin
            next_key_set = code_hit & par_ok & ds2;
            next_state   = MS_IDLE;
          end
        end
      end
      default:
      begin
        next_state = MS_IDLE;
      end
    endcase
    // Disabled logic holds idle and forgets partial frames
    if (!run)
    begin
      next_state    = MS_IDLE;
      next_bit_num  = 4'h0;
      next_high_cnt = 4'h0;
      next_key_set  = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state    <= MS_IDLE;
      ks1      <= 1'b1;
      ks2      <= 1'b1;
      kprev    <= 1'b1;
      ds1      <= 1'b1;
      ds2      <= 1'b1;
      high_cnt <= 4'h0;
      bit_num  <= 4'h0;
      shift    <= 8'h00;
      code_hit <= 1'b0;
      par_ok   <= 1'b0;
      key_set  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      ks1      <= next_ks1;
      ks2      <= next_ks2;
      kprev    <= next_kprev;
      ds1      <= next_ds1;
      ds2      <= next_ds2;
      high_cnt <= next_high_cnt;
      bit_num  <= next_bit_num;
      shift    <= next_shift;
      code_hit <= next_code_hit;
      par_ok   <= next_par_ok;
      key_set  <= next_key_set;
    end
  end

  // ------------------------------------------------------------
  // Wake pin
  // ------------------------------------------------------------
  always_comb
  begin
    pending    = (key_sts & key_en & ~clk_ctl[KDIS_BIT])
               | (grp_sts & grp_en);
    pin_active = global_en & pending & pin_ctl[FUNC_BIT];
    pin_level  = pin_active ? pin_ctl[POL_BIT] : ~pin_ctl[POL_BIT];
    next_wake_event_o = pin_level;
    // Open drain only pulls low; a high level is left to the pull-up
    if (!pin_ctl[FUNC_BIT])
    begin
      next_wake_event_oe_n = 1'b1;
    end
    else if (pin_ctl[ODRAIN_BIT])
    begin
      next_wake_event_oe_n = pin_level;
    end
    else
    begin
      next_wake_event_oe_n = 1'b0;
    end
    next_key_match_seen = key_set;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wake_event_o    <= 1'b1;
      wake_event_oe_n <= 1'b1;
      key_match_seen  <= 1'b0;
    end
    else
    begin
      wake_event_o    <= next_wake_event_o;
      wake_event_oe_n <= next_wake_event_oe_n;
      key_match_seen  <= next_key_match_seen;
    end
  end

endmodule
